// ---- src/dsb_pkg.sv ----
`default_nettype none
package dsb_pkg;
   // frame type codes carried in byte 0 of the first word
   localparam logic [7:0] FRAME_DMA_SETUP = 8'h41;
   localparam logic [7:0] FRAME_SELFTEST = 8'h58;
   // dma setup frame length in words
   localparam logic [2:0] DMA_SETUP_WORDS = 3'h7;
   // selftest frame: mode byte position in word 0
   localparam int SELFTEST_MODE_LSB = 16;
   // supported loopback mode bits, others unsupported
   localparam logic [7:0] SELFTEST_SUPPORTED = 8'hFF;
   localparam logic [7:0] SELFTEST_RESET_MODE = 8'h00;
   localparam logic [31:0] WORD_RESET = 32'h0000_0000;

   typedef struct packed {
      logic valid;
      logic sof;
      logic eof;
      logic crc_err;
      logic [31:0] data;
   } dsb_word_t;

   typedef struct packed {
      logic [31:0] w0;
      logic [31:0] w1;
      logic [31:0] w2;
      logic [31:0] w3;
      logic [31:0] w4;
      logic [31:0] w5;
      logic [31:0] w6;
   } dsb_setup_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_DMA_SETUP,
      ST_SELFTEST_CHECK,
      ST_SELFTEST_NOTIFY
   } dsb_state_t;
endpackage : dsb_pkg
`default_nettype wire

// ---- src/dsb_mode_check.sv ----
`timescale 1ns/100ps
`default_nettype none
module dsb_mode_check (
   input wire logic [7:0] mode,
   output logic valid
);
   // mode must be nonzero and only use supported bits
   assign valid = (mode != 8'h00) && ((mode & ~dsb_pkg::SELFTEST_SUPPORTED) == 8'h00);
endmodule : dsb_mode_check
`default_nettype wire

// ---- src/dsb_rx.sv ----
`timescale 1ns/100ps
`default_nettype none
module dsb_rx (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic clk_en,
   input wire dsb_pkg::dsb_word_t link_word,
   input wire logic link_illegal,
   output logic link_ready,
   output logic link_err_status,
   output logic app_setup_strobe,
   output dsb_pkg::dsb_setup_t app_setup,
   output logic app_loop_strobe,
   output logic [7:0] app_loop_mode,
   output logic busy
);
   dsb_pkg::dsb_state_t state_r, state_nxt;
   // last word goes straight to the output, so only six are held
   logic [31:0] hold_r [0:5];
   logic [2:0] cnt_r;
   logic err_r;
   logic [7:0] mode_r;
   logic setup_strobe_r, err_status_r, loop_strobe_r;
   dsb_pkg::dsb_setup_t setup_out_r;
   logic [7:0] loop_mode_r;

   wire logic start = clk_en && link_word.valid && link_word.sof;
   wire logic [7:0] ftype = link_word.data[7:0];
   wire logic is_setup = start && ftype == dsb_pkg::FRAME_DMA_SETUP;
   wire logic is_self = start && ftype == dsb_pkg::FRAME_SELFTEST;
   wire logic word_in = clk_en && link_word.valid;
   wire logic last = word_in && link_word.eof;
   // sof word is taken in idle, so the eof word arrives with cnt_r at length minus two
   wire logic frame_err = err_r || link_word.crc_err || cnt_r != 3'(dsb_pkg::DMA_SETUP_WORDS - 3'h2);
   wire logic mode_ok;

   dsb_mode_check u_chk (
      .mode(mode_r),
      .valid(mode_ok)
   );

   // no flow control ever: link may stream at full rate
   assign link_ready = 1'b1;
   assign link_err_status = err_status_r;
   assign app_setup_strobe = setup_strobe_r;
   assign app_setup = setup_out_r;
   assign app_loop_strobe = loop_strobe_r;
   assign app_loop_mode = loop_mode_r;
   assign busy = state_r != dsb_pkg::ST_IDLE;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         dsb_pkg::ST_IDLE: begin
            if (is_setup && !link_word.eof) state_nxt = dsb_pkg::ST_DMA_SETUP;
            else if (is_self) state_nxt = dsb_pkg::ST_SELFTEST_CHECK;
         end
         dsb_pkg::ST_DMA_SETUP: begin
            if (link_illegal) state_nxt = dsb_pkg::ST_IDLE;
            else if (last) state_nxt = dsb_pkg::ST_IDLE;
         end
         dsb_pkg::ST_SELFTEST_CHECK: begin
            if (link_illegal) state_nxt = dsb_pkg::ST_IDLE;
            else if (err_r) state_nxt = dsb_pkg::ST_IDLE;
            else if (mode_ok) state_nxt = dsb_pkg::ST_SELFTEST_NOTIFY;
            else state_nxt = dsb_pkg::ST_IDLE;
         end
         dsb_pkg::ST_SELFTEST_NOTIFY: state_nxt = dsb_pkg::ST_IDLE;
         default: state_nxt = dsb_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) state_r <= dsb_pkg::ST_IDLE;
      else if (clk_en) state_r <= state_nxt;
   end

   // capture words; frame error accumulates across the frame
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         cnt_r <= 3'h0;
         err_r <= 1'b0;
         mode_r <= dsb_pkg::SELFTEST_RESET_MODE;
      end else if (clk_en) begin
         if (state_r == dsb_pkg::ST_IDLE && start) begin
            cnt_r <= 3'h0;
            err_r <= link_word.crc_err || (is_self && !link_word.eof);
            mode_r <= link_word.data[dsb_pkg::SELFTEST_MODE_LSB +: 8];
         end else if (state_r == dsb_pkg::ST_DMA_SETUP && word_in) begin
            cnt_r <= cnt_r + 3'h1;
            err_r <= err_r || link_word.crc_err || cnt_r == 3'(dsb_pkg::DMA_SETUP_WORDS - 3'h1);
         end
      end
   end

   // holding registers, released only on clean receipt
   always_ff @(posedge sys_clk) begin
      if (clk_en && state_r == dsb_pkg::ST_IDLE && is_setup) hold_r[0] <= link_word.data;
      else if (clk_en && state_r == dsb_pkg::ST_DMA_SETUP && word_in && cnt_r < 3'h5)
         hold_r[cnt_r + 3'h1] <= link_word.data;
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         setup_strobe_r <= 1'b0;
         err_status_r <= 1'b0;
         loop_strobe_r <= 1'b0;
         loop_mode_r <= dsb_pkg::SELFTEST_RESET_MODE;
         setup_out_r <= '0;
      end else if (clk_en) begin
         setup_strobe_r <= 1'b0;
         err_status_r <= 1'b0;
         loop_strobe_r <= 1'b0;
         if (state_r == dsb_pkg::ST_DMA_SETUP && last && !link_illegal) begin
            if (!frame_err) begin
               setup_strobe_r <= 1'b1;
               setup_out_r <= {hold_r[0], hold_r[1], hold_r[2], hold_r[3], hold_r[4], hold_r[5],
                               link_word.data};
            end else begin
               err_status_r <= 1'b1;
            end
         end
         if (state_r == dsb_pkg::ST_SELFTEST_NOTIFY) begin
            loop_strobe_r <= 1'b1;
            loop_mode_r <= mode_r;
         end
      end
   end

   sequence setup_end_s;
      clk_en && state_r == dsb_pkg::ST_DMA_SETUP && last && !link_illegal;
   endsequence

   flow_never_a: assert property (@(posedge sys_clk) disable iff (reset) link_ready)
      else $error("link throttled");
   setup_enter_a: assert property (@(posedge sys_clk) disable iff (reset)
      state_r == dsb_pkg::ST_IDLE && is_setup && !link_word.eof |=> state_r == dsb_pkg::ST_DMA_SETUP)
      else $error("setup state not entered");
   setup_good_a: assert property (@(posedge sys_clk) disable iff (reset)
      setup_end_s and !frame_err |=> app_setup_strobe && !link_err_status && state_r == dsb_pkg::ST_IDLE)
      else $error("clean setup not delivered");
   setup_bad_a: assert property (@(posedge sys_clk) disable iff (reset)
      setup_end_s and frame_err |=> link_err_status && !app_setup_strobe)
      else $error("errored setup not reported");
   illegal_idle_a: assert property (@(posedge sys_clk) disable iff (reset)
      clk_en && link_illegal && state_r != dsb_pkg::ST_SELFTEST_NOTIFY |=> state_r == dsb_pkg::ST_IDLE)
      else $error("illegal report ignored");
   self_enter_a: assert property (@(posedge sys_clk) disable iff (reset)
      state_r == dsb_pkg::ST_IDLE && is_self |=> state_r == dsb_pkg::ST_SELFTEST_CHECK)
      else $error("selftest check not entered");
   self_valid_a: assert property (@(posedge sys_clk) disable iff (reset)
      clk_en && state_r == dsb_pkg::ST_SELFTEST_CHECK && !link_illegal && !err_r && mode_ok
      |=> state_r == dsb_pkg::ST_SELFTEST_NOTIFY)
      else $error("valid selftest not notified");
   self_drop_a: assert property (@(posedge sys_clk) disable iff (reset)
      clk_en && state_r == dsb_pkg::ST_SELFTEST_CHECK && (err_r || !mode_ok)
      |=> state_r == dsb_pkg::ST_IDLE ##1 !app_loop_strobe)
      else $error("bad selftest not dropped");
   notify_pulse_a: assert property (@(posedge sys_clk) disable iff (reset)
      clk_en && state_r == dsb_pkg::ST_SELFTEST_NOTIFY
      |=> app_loop_strobe && app_loop_mode == $past(mode_r) && state_r == dsb_pkg::ST_IDLE)
      else $error("notify missing");
   strobe_single_a: assert property (@(posedge sys_clk) disable iff (reset)
      app_loop_strobe && clk_en |=> !app_loop_strobe)
      else $error("mode strobe too long");
endmodule : dsb_rx
`default_nettype wire

// ---- test/dsb_link_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module dsb_link_model (
   input wire logic sys_clk,
   output dsb_pkg::dsb_word_t link_word,
   output logic link_illegal
);
   initial begin
      link_word = '0;
      link_illegal = 1'b0;
   end
   task automatic send(input logic [31:0] d, input logic s, input logic e, input logic c);
      @(posedge sys_clk);
      link_word <= '{1'b1, s, e, c, d};
   endtask : send
   // released bus shows inverted data, not a stale copy
   task automatic idle();
      @(posedge sys_clk);
      link_word <= '{1'b0, 1'b0, 1'b0, 1'b0, ~link_word.data};
   endtask : idle
   task automatic illegal();
      idle();
      link_illegal <= 1'b1;
      @(posedge sys_clk);
      link_illegal <= 1'b0;
   endtask : illegal
endmodule : dsb_link_model
`default_nettype wire

// ---- test/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic clk_en = 1'b1;
   dsb_pkg::dsb_word_t link_word;
   dsb_pkg::dsb_setup_t app_setup;
   logic link_illegal, link_ready, link_err_status, app_setup_strobe, app_loop_strobe, busy;
   logic [7:0] app_loop_mode;
   logic [223:0] last_setup = '0;
   logic [3:0] ns, ne, nl;
   int mismatches = 0;
   int checks = 0;
   always #5 sys_clk = ~sys_clk;
   dsb_link_model u_link (.sys_clk(sys_clk), .link_word(link_word), .link_illegal(link_illegal));
   dsb_rx u_dut (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en), .link_word(link_word),
      .link_illegal(link_illegal), .link_ready(link_ready), .link_err_status(link_err_status),
      .app_setup_strobe(app_setup_strobe), .app_setup(app_setup), .app_loop_strobe(app_loop_strobe),
      .app_loop_mode(app_loop_mode), .busy(busy));
   task automatic cmp(input logic [223:0] got, input logic [223:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp
   // window covers the slowest answer, three cycles after a selftest word
   task automatic watch(input logic [3:0] es, input logic [3:0] ee, input logic [3:0] el);
      ns = '0;
      ne = '0;
      nl = '0;
      repeat (6) begin
         @(negedge sys_clk);
         ns = ns + 4'(app_setup_strobe);
         ne = ne + 4'(link_err_status);
         nl = nl + 4'(app_loop_strobe);
      end
      cmp(224'(ns), 224'(es));
      cmp(224'(ne), 224'(ee));
      cmp(224'(nl), 224'(el));
      cmp(224'(busy), 224'h0);
   endtask : watch
   task automatic t_setup(input int n, input int bad);
      logic [223:0] exp;
      logic [31:0] d;
      logic ok;
      exp = last_setup;
      for (int i = 0; i < n; i++) begin
         d = (i == 0) ? {24'h123456, dsb_pkg::FRAME_DMA_SETUP} : 32'hC0DE0000 + 32'(i);
         exp = {exp[191:0], d};
         u_link.send(d, i == 0, i == n - 1, i == bad);
         cmp(224'(link_ready), 224'h1);
      end
      u_link.idle();
      ok = (n == 7) && (bad < 0);
      watch(4'(ok), 4'(!ok), 4'h0);
      if (ok) last_setup = exp;
      cmp(app_setup, last_setup);
   endtask : t_setup
   task automatic t_ill_setup();
      u_link.send({24'h0, dsb_pkg::FRAME_DMA_SETUP}, 1'b1, 1'b0, 1'b0);
      u_link.send(32'h5A5A0001, 1'b0, 1'b0, 1'b0);
      u_link.illegal();
      u_link.send(32'h5A5A0002, 1'b0, 1'b1, 1'b0);
      u_link.idle();
      watch(4'h0, 4'h0, 4'h0);
      cmp(app_setup, last_setup);
   endtask : t_ill_setup
   task automatic t_self(input logic [7:0] mode, input logic crc, input logic ill, input logic ok);
      u_link.send({8'h0, mode, 8'h0, dsb_pkg::FRAME_SELFTEST}, 1'b1, 1'b1, crc);
      if (ill) u_link.illegal();
      else u_link.idle();
      watch(4'h0, 4'h0, 4'(ok));
      if (ok) cmp(224'(app_loop_mode), 224'(mode));
   endtask : t_self
   // clock enable low must freeze the notify state and hold back the pulse
   task automatic t_freeze();
      u_link.send({8'h0, 8'h05, 8'h0, dsb_pkg::FRAME_SELFTEST}, 1'b1, 1'b1, 1'b0);
      u_link.idle();
      @(posedge sys_clk);
      clk_en <= 1'b0;
      repeat (4) begin
         @(negedge sys_clk);
         cmp(224'({app_loop_strobe, busy}), 224'h1);
      end
      @(posedge sys_clk);
      clk_en <= 1'b1;
      watch(4'h0, 4'h0, 4'h1);
      cmp(224'(app_loop_mode), 224'h05);
   endtask : t_freeze
   task automatic print_verdict();
      if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict
   initial begin
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      t_setup(7, -1);
      t_setup(7, 3);
      t_setup(6, -1);
      t_ill_setup();
      t_setup(7, 6);
      t_setup(7, -1);
      for (int b = 0; b < 8; b++) t_self(8'h01 << b, 1'b0, 1'b0, 1'b1);
      t_self(8'h00, 1'b0, 1'b0, 1'b0);
      t_self(8'hFF, 1'b1, 1'b0, 1'b0);
      t_self(8'h22, 1'b0, 1'b1, 1'b0);
      t_self(8'hFF, 1'b0, 1'b0, 1'b1);
      t_freeze();
      print_verdict();
   end
endmodule : tb
`default_nettype wire
